/* verilog/zsr_pkg.sv */
// Constants and types for the zero sequence recloser
// How it works
// (RL1) Recloser works only while enable is high
// (RL2) Disabled: blocked out high, never close; forcing still overrides both while disabled
// (RL3) Trip input starts a reclosing sequence
// (RL4) Active output held from trip until clear
// (RL5) Blocked input active: close after delay
// (RL6) Close only if blocked stays active throughout
// (RL7) Delay programmable 0 to 1800 seconds
// (RL8) Close command asserted once delay elapsed
// (RL9) Protection block output held until fault clears
// (RL10) Force status overrides state when forcing enabled
// (RL11) Force status is static, not per group
// (RL12) Read-only condition code 0 to 5
// (RL13) On/off events with millisecond stamps
// (RL14) Trip and blocked both low: return idle
// (RL15) Delay counted in ticks, restarts on drop
package zsr_pkg;

    // ********************************
    // Timing
    // ********************************
    localparam int CLK_HZ        = 250_000_000;
    localparam int MS_PER_S      = 1000;
    localparam int TICKS_PER_MS  = CLK_HZ / MS_PER_S;
    localparam int DELAY_MAX_MS  = 1_800_000;
    localparam int MS_CNT_W      = 18;
    localparam int DELAY_W       = 21;
    localparam int STAMP_W       = 32;

    // ********************************
    // Register map
    // ********************************
    localparam logic [7:0] OFS_CTRL   = 8'h00;
    localparam logic [7:0] OFS_DELAY  = 8'h04;
    localparam logic [7:0] OFS_STATUS = 8'h08;
    localparam logic [7:0] OFS_IRQ_ST = 8'h0c;
    localparam logic [7:0] OFS_IRQ_EN = 8'h10;
    localparam logic [7:0] OFS_IRQ_CL = 8'h14;
    localparam logic [7:0] OFS_EVENT  = 8'h18;
    localparam logic [7:0] OFS_STAMP  = 8'h1c;

    localparam int CTRL_FORCE_EN = 0;
    localparam int CTRL_FORCE_LO = 4;
    localparam int CTRL_FORCE_W  = 3;
    localparam int EV_N          = 5;
    localparam int EV_W          = 10;

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Force encodings
    localparam logic [2:0] FRC_NORMAL = 3'h0;
    localparam logic [2:0] FRC_BLOCK  = 3'h1;
    localparam logic [2:0] FRC_REQ    = 3'h2;
    localparam logic [2:0] FRC_CLOSE  = 3'h3;
    localparam logic [2:0] FRC_CLOSED = 3'h4;

    // Condition codes
    localparam logic [2:0] CND_NORMAL = 3'h0;
    localparam logic [2:0] CND_REQ    = 3'h1;
    localparam logic [2:0] CND_BLOCK  = 3'h2;
    localparam logic [2:0] CND_ACTIVE = 3'h3;
    localparam logic [2:0] CND_CLOSE  = 3'h4;
    localparam logic [2:0] CND_CLOSED = 3'h5;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_ACTIVE,
        ST_CLOSED
    } zsr_state_t;

endpackage

/* verilog/zsr_recloser.sv */
// Zero sequence recloser with AXI4-Lite registers
`timescale 1ns/10ps
`default_nettype none
module zsr_recloser
    import zsr_pkg::*;
(
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        SYS_RST,
    // Protection side
    input  wire logic        RECL_ENABLE,
    input  wire logic        NEUTRAL_OV_TRIP,
    input  wire logic        NEUTRAL_OV_BLOCKED,
    // Breaker and protection outputs
    output logic             RECL_BLOCKED,
    output logic             RECL_ACTIVE,
    output logic             BREAKER_CLOSE,
    output logic             PROTECTION_BLOCK_OUT,
    output logic             IRQ,
    // AXI4-Lite write
    input  wire logic [7:0]  AWADDR,
    input  wire logic        AWVALID,
    output logic             AWREADY,
    input  wire logic [31:0] WDATA,
    input  wire logic [3:0]  WSTRB,
    input  wire logic        WVALID,
    output logic             WREADY,
    output logic [1:0]       BRESP,
    output logic             BVALID,
    input  wire logic        BREADY,
    // AXI4-Lite read
    input  wire logic [7:0]  ARADDR,
    input  wire logic        ARVALID,
    output logic             ARREADY,
    output logic [31:0]      RDATA,
    output logic [1:0]       RRESP,
    output logic             RVALID,
    input  wire logic        RREADY
);

    // ********************************
    // Declarations
    // ********************************
    zsr_state_t               state_ff;
    logic [DELAY_W-1:0]       delay_ms_ff;
    logic [DELAY_W-1:0]       elapsed_ms_ff;
    logic [MS_CNT_W-1:0]      tick_ff;
    logic [STAMP_W-1:0]       stamp_ff;
    logic                     force_en_ff;
    logic [CTRL_FORCE_W-1:0]  force_ff;
    logic [EV_W-1:0]          irq_st_ff;
    logic [EV_W-1:0]          irq_en_ff;
    logic [EV_W-1:0]          ev_last_ff;
    logic [STAMP_W-1:0]       ev_stamp_ff;
    logic [EV_N-1:0]          lvl_prev_ff;
    logic [EV_N-1:0]          lvl;
    logic [EV_W-1:0]          ev_now;
    logic                     ms_tick;
    logic                     expired;
    logic                     fault_gone;
    logic                     nxt_blocked;
    logic                     nxt_active;
    logic                     nxt_close;
    logic                     nxt_pblock;
    logic [2:0]               cond;
    logic                     aw_got_ff;
    logic                     w_got_ff;
    logic [7:0]               aw_addr_ff;
    logic [31:0]              w_data_ff;
    logic [3:0]               w_strb_ff;
    logic                     wr_go;
    logic [EV_W-1:0]          clr_bits;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  be);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return r;
    endfunction

    // ********************************
    // Millisecond time base
    // ********************************
    assign ms_tick = (tick_ff == MS_CNT_W'(TICKS_PER_MS - 1));

    always_ff @(posedge CLK) begin
        if (SYS_RST || ms_tick) begin
            tick_ff <= '0;
        end else begin
            tick_ff <= tick_ff + 1'b1;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            stamp_ff <= '0;
        end else if (ms_tick) begin
            stamp_ff <= stamp_ff + 1'b1;
        end
    end

    // ********************************
    // Sequence
    // ********************************
    assign fault_gone = !NEUTRAL_OV_TRIP && !NEUTRAL_OV_BLOCKED;
    assign expired    = (elapsed_ms_ff >= delay_ms_ff);

    always_ff @(posedge CLK) begin
        if (SYS_RST || !RECL_ENABLE) begin // see (RL1)
            state_ff <= ST_IDLE;
        end else begin
            unique case (state_ff)
                ST_IDLE: begin
                    if (NEUTRAL_OV_TRIP) begin // see (RL3)
                        state_ff <= ST_ACTIVE;
                    end
                end
                ST_ACTIVE: begin
                    if (fault_gone) begin // see (RL14)
                        state_ff <= ST_IDLE;
                    end else if (NEUTRAL_OV_BLOCKED && expired) begin
                        state_ff <= ST_CLOSED; // see (RL5) (RL8)
                    end
                end
                ST_CLOSED: begin
                    if (fault_gone) begin // see (RL14)
                        state_ff <= ST_IDLE;
                    end
                end
            endcase
        end
    end

    // Counts whole ms while blocked holds; a drop loses the progress
    always_ff @(posedge CLK) begin
        if (SYS_RST || state_ff != ST_ACTIVE || !NEUTRAL_OV_BLOCKED) begin
            elapsed_ms_ff <= '0; // see (RL6) (RL15)
        end else if (ms_tick && !expired) begin
            elapsed_ms_ff <= elapsed_ms_ff + 1'b1; // see (RL7)
        end
    end

    // ********************************
    // Outputs with forcing
    // ********************************
    always_comb begin
        nxt_blocked = !RECL_ENABLE; // see (RL2)
        nxt_active  = RECL_ENABLE && state_ff != ST_IDLE; // see (RL4)
        nxt_close   = RECL_ENABLE && state_ff == ST_CLOSED;
        nxt_pblock  = RECL_ENABLE && state_ff == ST_CLOSED; // see (RL9)
        if (force_en_ff) begin // see (RL10) (RL11)
            unique case (force_ff)
                FRC_BLOCK: begin
                    nxt_blocked = 1'b1;
                    nxt_active  = 1'b0;
                    nxt_close   = 1'b0;
                    nxt_pblock  = 1'b0;
                end
                FRC_REQ: begin
                    nxt_blocked = 1'b0;
                    nxt_active  = 1'b1;
                    nxt_close   = 1'b0;
                    nxt_pblock  = 1'b0;
                end
                FRC_CLOSE, FRC_CLOSED: begin
                    nxt_blocked = 1'b0;
                    nxt_active  = 1'b1;
                    nxt_close   = 1'b1;
                    nxt_pblock  = 1'b1;
                end
                default: begin
                end
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            RECL_BLOCKED         <= 1'b1;
            RECL_ACTIVE          <= 1'b0;
            BREAKER_CLOSE        <= 1'b0;
            PROTECTION_BLOCK_OUT <= 1'b0;
        end else begin
            RECL_BLOCKED         <= nxt_blocked;
            RECL_ACTIVE          <= nxt_active;
            BREAKER_CLOSE        <= nxt_close && !nxt_blocked; // see (RL2)
            PROTECTION_BLOCK_OUT <= nxt_pblock;
        end
    end

    // Condition code, from the registered outputs and the trip input
    always_comb begin
        if (RECL_BLOCKED) begin
            cond = CND_BLOCK; // see (RL12)
        end else if (PROTECTION_BLOCK_OUT) begin
            cond = CND_CLOSED;
        end else if (BREAKER_CLOSE) begin
            cond = CND_CLOSE;
        end else if (RECL_ACTIVE) begin
            cond = CND_ACTIVE;
        end else if (NEUTRAL_OV_TRIP) begin
            cond = CND_REQ;
        end else begin
            cond = CND_NORMAL;
        end
    end

    // ********************************
    // Events: even bit on, odd bit off
    // ********************************
    assign lvl = {PROTECTION_BLOCK_OUT, BREAKER_CLOSE, RECL_ACTIVE,
                  RECL_BLOCKED, NEUTRAL_OV_TRIP};

    always_comb begin
        for (int i = 0; i < EV_N; i++) begin
            ev_now[2*i]   = lvl[i] && !lvl_prev_ff[i];
            ev_now[2*i+1] = !lvl[i] && lvl_prev_ff[i];
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            lvl_prev_ff <= 5'h02;
        end else begin
            lvl_prev_ff <= lvl;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ev_last_ff  <= '0;
            ev_stamp_ff <= '0;
        end else if (|ev_now) begin
            ev_last_ff  <= ev_now; // see (RL13)
            ev_stamp_ff <= stamp_ff;
        end
    end

    // Set wins over a clear in the same cycle
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            irq_st_ff <= '0;
        end else begin
            irq_st_ff <= (irq_st_ff & ~clr_bits) | ev_now;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(((irq_st_ff & ~clr_bits) | ev_now) & irq_en_ff);
        end
    end

    // ********************************
    // AXI4-Lite write
    // ********************************
    assign wr_go    = aw_got_ff && w_got_ff && !BVALID;
    assign clr_bits = (wr_go && aw_addr_ff == OFS_IRQ_CL)
                      ? EV_W'(merge('0, w_data_ff, w_strb_ff)) : '0;

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            aw_got_ff  <= 1'b0;
            aw_addr_ff <= '0;
        end else if (AWVALID && AWREADY) begin
            aw_got_ff  <= 1'b1;
            aw_addr_ff <= AWADDR;
        end else if (wr_go) begin
            aw_got_ff  <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            w_got_ff  <= 1'b0;
            w_data_ff <= '0;
            w_strb_ff <= '0;
        end else if (WVALID && WREADY) begin
            w_got_ff  <= 1'b1;
            w_data_ff <= WDATA;
            w_strb_ff <= WSTRB;
        end else if (wr_go) begin
            w_got_ff  <= 1'b0;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            AWREADY <= 1'b0;
            WREADY  <= 1'b0;
        end else begin
            AWREADY <= !aw_got_ff && !(AWVALID && AWREADY) && !BVALID;
            WREADY  <= !w_got_ff && !(WVALID && WREADY) && !BVALID;
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            BVALID <= 1'b0;
            BRESP  <= RESP_OKAY;
        end else if (wr_go) begin
            BVALID <= 1'b1;
            unique case (aw_addr_ff)
                OFS_CTRL, OFS_DELAY, OFS_IRQ_EN, OFS_IRQ_CL: begin
                    BRESP <= RESP_OKAY;
                end
                default: begin
                    BRESP <= RESP_SLVERR;
                end
            endcase
        end else if (BVALID && BREADY) begin
            BVALID <= 1'b0;
        end
    end

    // Delay write is clamped at the top of the range
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            force_en_ff <= 1'b0;
            force_ff    <= FRC_NORMAL;
            delay_ms_ff <= '0;
            irq_en_ff   <= '0;
        end else if (wr_go) begin
            unique case (aw_addr_ff)
                OFS_CTRL: begin
                    if (w_strb_ff[0]) begin
                        force_en_ff <= w_data_ff[CTRL_FORCE_EN];
                        force_ff    <= w_data_ff[CTRL_FORCE_LO +:
                                                 CTRL_FORCE_W];
                    end
                end
                OFS_DELAY: begin
                    if (merge(32'h0, w_data_ff, w_strb_ff)
                        > DELAY_MAX_MS) begin
                        delay_ms_ff <= DELAY_W'(DELAY_MAX_MS);
                    end else begin
                        delay_ms_ff <= DELAY_W'(merge(32'h0, w_data_ff,
                                                      w_strb_ff));
                    end
                end
                OFS_IRQ_EN: begin
                    irq_en_ff <= EV_W'(merge({22'h0, irq_en_ff},
                                             w_data_ff, w_strb_ff));
                end
                default: begin
                end
            endcase
        end
    end

    // ********************************
    // AXI4-Lite read
    // ********************************
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b0;
            RDATA   <= '0;
            RRESP   <= RESP_OKAY;
        end else if (ARVALID && ARREADY) begin
            ARREADY <= 1'b0;
            RVALID  <= 1'b1;
            RRESP   <= RESP_OKAY;
            unique case (ARADDR)
                OFS_CTRL:   RDATA <= {25'h0, force_ff, 3'h0, force_en_ff};
                OFS_DELAY:  RDATA <= {11'h0, delay_ms_ff};
                OFS_STATUS: RDATA <= {24'h0, lvl, cond};
                OFS_IRQ_ST: RDATA <= {22'h0, irq_st_ff};
                OFS_IRQ_EN: RDATA <= {22'h0, irq_en_ff};
                OFS_IRQ_CL: RDATA <= '0;
                OFS_EVENT:  RDATA <= {22'h0, ev_last_ff};
                OFS_STAMP:  RDATA <= ev_stamp_ff;
                default: begin
                    RDATA <= '0;
                    RRESP <= RESP_SLVERR;
                end
            endcase
        end else if (RVALID && RREADY) begin
            RVALID <= 1'b0;
        end else if (!RVALID) begin
            ARREADY <= 1'b1;
        end
    end

    // ********************************
    // Checks
    // ********************************
    disabled_no_close_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !RECL_ENABLE |=> RECL_BLOCKED && !BREAKER_CLOSE) // see (RL2)
        else $error("Close or unblocked while disabled");
    trip_starts_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        RECL_ENABLE && NEUTRAL_OV_TRIP && state_ff == ST_IDLE
        |=> state_ff == ST_ACTIVE) // see (RL3)
        else $error("Trip did not start sequence");
    active_held_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        state_ff == ST_ACTIVE && RECL_ENABLE && !force_en_ff
        |=> RECL_ACTIVE) // see (RL4)
        else $error("Active output dropped in sequence");
    close_needs_hold_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(state_ff == ST_CLOSED) |-> $past(NEUTRAL_OV_BLOCKED)
        && $past(elapsed_ms_ff) >= $past(delay_ms_ff)) // see (RL6)
        else $error("Close without full blocked hold");
    close_follows_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        state_ff == ST_CLOSED && RECL_ENABLE && !force_en_ff
        |=> BREAKER_CLOSE && PROTECTION_BLOCK_OUT) // see (RL8) (RL9)
        else $error("Close or protection block missing");
    restart_drop_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        !NEUTRAL_OV_BLOCKED |=> elapsed_ms_ff == '0) // see (RL15)
        else $error("Delay count kept after drop");
    clear_idle_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        fault_gone && state_ff != ST_IDLE |=> state_ff == ST_IDLE
        ##1 !PROTECTION_BLOCK_OUT || force_en_ff) // see (RL14)
        else $error("No return to idle on clear");
    event_seen_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        $rose(RECL_ACTIVE) |=> irq_st_ff[4]) // see (RL13)
        else $error("Active on event not latched");
    forced_block_a: assert property (@(posedge CLK) disable iff (SYS_RST)
        force_en_ff && force_ff == FRC_BLOCK |=> RECL_BLOCKED) // see (RL10)
        else $error("Forced block not shown");

endmodule
`default_nettype wire

/* dv/zsr_feeder_model.sv */
// Feeder model: neutral overvoltage protection and its breaker
`timescale 1ns/10ps
`default_nettype none
module zsr_feeder_model #(
    parameter int PICKUP = 4
) (
    // Clock and reset
    input  wire logic clk,
    input  wire logic rst,
    // Fault stimulus
    input  wire logic fault_on,
    input  wire logic fault_here,
    // From recloser
    input  wire logic block_in,
    input  wire logic close_cmd,
    // To recloser
    output logic      trip,
    output logic      blocked
);
    logic       brk_closed_ff;
    logic [3:0] pick_ff;
    logic       nvolt_high;

    // Own-feeder fault vanishes once this breaker is open
    assign nvolt_high = fault_on && !(fault_here && !brk_closed_ff);
    assign trip       = (pick_ff == 4'(PICKUP));
    // Blocked to recloser: voltage high while the recloser blocks protection or breaker is open
    assign blocked    = nvolt_high && (block_in || !brk_closed_ff);

    always_ff @(posedge clk) begin
        if (rst) begin
            brk_closed_ff <= 1'b1;
        end else if (trip) begin
            brk_closed_ff <= 1'b0;
        end else if (close_cmd) begin
            brk_closed_ff <= 1'b1;
        end
    end

    // Pick-up delay: no trip while blocked or open
    always_ff @(posedge clk) begin
        if (rst || !nvolt_high || block_in || !brk_closed_ff) begin
            pick_ff <= 4'h0;
        end else if (!trip) begin
            pick_ff <= pick_ff + 4'h1;
        end
    end
endmodule
`default_nettype wire

/* dv/tb.sv */
// Self-checking bench for the zero sequence recloser
`timescale 1ns/10ps
`default_nettype none
module tb
    import zsr_pkg::*;
;
    localparam int LIMIT = 40000;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        en = 1'b0;
    logic        f_on = 1'b0;
    logic        f_here = 1'b0;
    logic        trip, blk, o_blk, o_act, o_cls, o_pb, irq;
    logic [7:0]  awaddr = 8'h00;
    logic [7:0]  araddr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic [3:0]  wstrb = 4'h0;
    logic        awvalid = 1'b0;
    logic        wvalid = 1'b0;
    logic        bready = 1'b0;
    logic        arvalid = 1'b0;
    logic        rready = 1'b0;
    logic        awready, wready, bvalid, arready, rvalid;
    logic [1:0]  bresp, rresp;
    logic [31:0] rdata;
    int          error_cnt = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    logic [3:0]  fexp [1:4] = '{4'b1000, 4'b0100, 4'b0111, 4'b0111};

    always #2 clk = ~clk;

    zsr_recloser i_dut (
        .CLK(clk), .SYS_RST(rst), .RECL_ENABLE(en),
        .NEUTRAL_OV_TRIP(trip), .NEUTRAL_OV_BLOCKED(blk),
        .RECL_BLOCKED(o_blk), .RECL_ACTIVE(o_act), .BREAKER_CLOSE(o_cls),
        .PROTECTION_BLOCK_OUT(o_pb), .IRQ(irq),
        .AWADDR(awaddr), .AWVALID(awvalid), .AWREADY(awready),
        .WDATA(wdata), .WSTRB(wstrb), .WVALID(wvalid), .WREADY(wready),
        .BRESP(bresp), .BVALID(bvalid), .BREADY(bready),
        .ARADDR(araddr), .ARVALID(arvalid), .ARREADY(arready),
        .RDATA(rdata), .RRESP(rresp), .RVALID(rvalid), .RREADY(rready)
    );

    zsr_feeder_model i_feeder (
        .clk(clk), .rst(rst), .fault_on(f_on), .fault_here(f_here),
        .block_in(o_pb), .close_cmd(o_cls), .trip(trip), .blocked(blk)
    );

    // ********************************
    // Reporting
    // ********************************
    task automatic stop_test;
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == LIMIT) begin
            error_cnt++;
            stop_test();
        end
    end

    // ********************************
    // Bus access
    // ********************************
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] er);
        @(posedge clk);
        awaddr <= a;
        wdata <= d;
        wstrb <= 4'hf;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge clk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!(bvalid && bready));
        chk({30'h0, bresp}, {30'h0, er});
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] m,
                      input logic [31:0] exp, input logic [1:0] er);
        @(posedge clk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge clk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!(rvalid && rready));
        chk(rdata & m, exp);
        chk({30'h0, rresp}, {30'h0, er});
        rready <= 1'b0;
    endtask

    task automatic outs(input logic [3:0] exp);
        chk({28'h0, o_blk, o_act, o_cls, o_pb}, {28'h0, exp});
    endtask

    task automatic idle(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Restart both the recloser and the feeder with a fresh breaker
    task automatic reinit(input logic e, input logic [31:0] dly);
        rst <= 1'b1;
        f_on <= 1'b0;
        f_here <= 1'b0;
        en <= e;
        idle(6);
        rst <= 1'b0;
        idle(2);
        wr(OFS_DELAY, dly, RESP_OKAY);
    endtask

    // ********************************
    // Scenarios
    // ********************************
    initial begin
        reinit(1'b0, 32'h0);
        outs(4'b1000);
        rd(OFS_CTRL, 32'hffffffff, 32'h0, RESP_OKAY);
        rd(OFS_STATUS, 32'h7, {29'h0, CND_BLOCK}, RESP_OKAY);
        rd(8'h20, 32'hffffffff, 32'h0, RESP_SLVERR);
        wr(OFS_STATUS, 32'h1, RESP_SLVERR);
        wr(OFS_DELAY, 32'h1b7741, RESP_OKAY);
        rd(OFS_DELAY, 32'hffffffff, 32'h1b7740, RESP_OKAY);
        f_on <= 1'b1;
        idle(40);
        outs(4'b1000);
        // Fault elsewhere, zero delay: reclose and hold the block
        reinit(1'b1, 32'h0);
        rd(OFS_STATUS, 32'h7, {29'h0, CND_NORMAL}, RESP_OKAY);
        f_on <= 1'b1;
        idle(40);
        outs(4'b0111);
        rd(OFS_STATUS, 32'h7, {29'h0, CND_CLOSED}, RESP_OKAY);
        chk({31'h0, irq}, 32'h0);
        f_on <= 1'b0;
        idle(10);
        outs(4'b0000);
        rd(OFS_IRQ_ST, 32'h3f3, 32'h3f3, RESP_OKAY);
        // Fault on own feeder: trip clears it, no reclose
        reinit(1'b1, 32'h0);
        wr(OFS_IRQ_EN, 32'h1, RESP_OKAY);
        f_here <= 1'b1;
        f_on <= 1'b1;
        idle(40);
        outs(4'b0000);
        rd(OFS_IRQ_ST, 32'h71, 32'h31, RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
        wr(OFS_IRQ_CL, 32'h3ff, RESP_OKAY);
        idle(3);
        chk({31'h0, irq}, 32'h0);
        rd(OFS_EVENT, 32'h3ff, 32'h020, RESP_OKAY);
        rd(OFS_STAMP, 32'hffffffff, 32'h0, RESP_OKAY);
        // Blocked held but shorter than the delay, then disable
        reinit(1'b1, 32'h2);
        f_on <= 1'b1;
        idle(2000);
        outs(4'b0100);
        en <= 1'b0;
        idle(5);
        outs(4'b1000);
        // Forced states only with forcing enabled
        reinit(1'b1, 32'h0);
        for (int c = 1; c <= 4; c++) begin
            wr(OFS_CTRL, 32'(c) << 4, RESP_OKAY);
            idle(4);
            outs(4'b0000);
            wr(OFS_CTRL, (32'(c) << 4) | 32'h1, RESP_OKAY);
            idle(4);
            outs(fexp[c]);
        end
        stop_test();
    end
endmodule
`default_nettype wire
